/* rtl/afa_unit.sv */
// atomic fetch-add unit: issue side, translation, locked memory rmw, registers
//
// Behaviour
// - read 4 or 8 bytes, width from the form, at the address register
// - zero-extend the read value and add the sign-extended increment
// - increment is one of -16, -8, -4, -1, 1, 4, 8, 16
// - write low 4 or 8 bytes of the sum to the same address
// - old value zero-extended to destination, destination token bit cleared
// - acquire: read and write visible before any later data access
// - release: read and write visible only after every earlier access
// - memory and unit keep read and write indivisible
// - misaligned address faults regardless of the user alignment check bit
// - both read and write privilege needed on the page
// - write privilege checked even when no write would happen
// - locality hint never changes the result and may be ignored
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module afa_unit
    import afa_pkg::*;
#(
    parameter int REG_AW = 8
)
(
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic ce,
    // issue side
    input wire logic issue_valid,
    input wire afa_req_s issue_req,
    output logic issue_ready,
    output logic wb_valid,
    output afa_wb_s wb,
    output logic fault_valid,
    output afa_fault_e fault_code,
    // translation and privilege
    output logic tr_req,
    output logic [63:0] tr_vaddr,
    input wire logic tr_ack,
    input wire logic tr_rd_ok,
    input wire logic tr_wr_ok,
    input wire logic [63:0] tr_paddr,
    // data memory
    input wire logic ord_prior_idle,
    output logic ord_acq_hold,
    output logic mem_lock,
    output logic mem_rd_req,
    output logic mem_wr_req,
    output logic mem_size8,
    output logic [1:0] mem_ldhint,
    output logic [63:0] mem_paddr,
    output logic [63:0] mem_wr_data,
    input wire logic mem_rd_ack,
    input wire logic [63:0] mem_rd_data,
    input wire logic mem_wr_ack,
    // register port
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);

    // elaboration check: the register map needs eight address bits
    if (REG_AW < 8)
    begin
        $error("afa_unit: REG_AW must be at least 8");
    end

    // ***********************************************
    // state
    // ***********************************************
    afa_state_e state_r, state_nxt;
    afa_req_s op_r;
    logic [63:0] paddr_r;
    logic [63:0] old_r;
    logic [63:0] sum_val;
    logic en_r;
    logic [AFA_ST_W-1:0] status_r, mask_r;
    logic [31:0] count_r;
    logic [31:0] rdata_r;

    // ***********************************************
    // decode
    // ***********************************************
    wire accept = issue_valid && issue_ready;
    wire acc_skip = accept && !issue_req.qp;
    wire acc_nat = accept && issue_req.qp && issue_req.addr_nat;
    wire acc_unal = accept && issue_req.qp && !issue_req.addr_nat
        && afa_misaligned(issue_req.wide, issue_req.addr);
    wire acc_go = accept && issue_req.qp && !issue_req.addr_nat
        && !afa_misaligned(issue_req.wide, issue_req.addr);
    wire xl_done = (state_r == ST_XLATE) && tr_ack;
    wire priv_ok = tr_rd_ok && tr_wr_ok;
    wire priv_bad = xl_done && !priv_ok;
    wire rd_done = (state_r == ST_READ) && mem_rd_ack;
    wire wr_done = (state_r == ST_WRITE) && mem_wr_ack;
    wire flt_any = acc_nat || acc_unal || priv_bad;
    wire [AFA_ST_W-1:0] ev_set = {priv_bad, acc_unal, acc_nat, (state_r == ST_DONE)};

    wire sel_ctrl = reg_addr == REG_AW'(AFA_OFS_CTRL);
    wire sel_status = reg_addr == REG_AW'(AFA_OFS_STATUS);
    wire sel_mask = reg_addr == REG_AW'(AFA_OFS_MASK);
    wire sel_lo = reg_addr == REG_AW'(AFA_OFS_RES_LO);
    wire sel_hi = reg_addr == REG_AW'(AFA_OFS_RES_HI);
    wire sel_cnt = reg_addr == REG_AW'(AFA_OFS_OPCOUNT);
    wire [AFA_ST_W-1:0] w1c = (reg_wr && sel_status) ? reg_wdata[AFA_ST_W-1:0] : '0;

    wire [31:0] rd_mux = sel_ctrl ? {31'h0, en_r}
        : sel_status ? {28'h0, status_r}
        : sel_mask ? {28'h0, mask_r}
        : sel_lo ? wb.data[31:0]
        : sel_hi ? wb.data[63:32]
        : sel_cnt ? count_r
        : 32'h0;

    // ***********************************************
    // outputs
    // ***********************************************
    assign issue_ready = ce && en_r && (state_r == ST_IDLE);
    assign tr_req = (state_r == ST_XLATE);
    assign tr_vaddr = op_r.addr;
    assign mem_rd_req = (state_r == ST_READ);
    assign mem_wr_req = (state_r == ST_WRITE);
    // location stays locked from the read until the write lands
    assign mem_lock = mem_rd_req || mem_wr_req;
    // later accesses held back until the acquire rmw is visible
    assign ord_acq_hold = op_r.acq && mem_lock;
    assign mem_size8 = op_r.wide;
    // hint only steers memory locality, never the data path
    assign mem_ldhint = op_r.ldhint;
    assign mem_paddr = paddr_r;
    assign mem_wr_data = sum_val;
    assign reg_rdata = rdata_r;
    assign irq = |(status_r & mask_r);

    afa_sum u_sum
    (
        .wide(op_r.wide),
        .inc_code(op_r.inc_code),
        .old_val(old_r),
        .new_val(sum_val)
    );

    // ***********************************************
    // sequencer
    // ***********************************************
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:
                if (acc_go)
                    state_nxt = ST_XLATE;
            ST_XLATE:
                if (xl_done)
                    state_nxt = priv_ok ? ST_ORDER : ST_IDLE;
            ST_ORDER:
                if (op_r.acq || ord_prior_idle)
                    state_nxt = ST_READ;
            ST_READ:
                if (mem_rd_ack)
                    state_nxt = ST_WRITE;
            ST_WRITE:
                if (mem_wr_ack)
                    state_nxt = ST_DONE;
            ST_DONE:
                state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            state_r <= ST_IDLE;
        else if (ce)
            state_r <= state_nxt;
    end

    // captured operation; skipped ops leave everything untouched
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            op_r <= '0;
        else if (ce && acc_go)
            op_r <= issue_req;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            paddr_r <= 64'h0;
        else if (ce && xl_done)
            paddr_r <= tr_paddr;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            old_r <= 64'h0;
        else if (ce && rd_done)
            old_r <= afa_zext(op_r.wide, mem_rd_data);
    end

    // ***********************************************
    // results and faults
    // ***********************************************
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wb_valid <= 1'b0;
            wb <= '0;
        end
        else if (ce)
        begin
            wb_valid <= wr_done;
            if (wr_done)
                wb <= '{dst: op_r.dst, nat: 1'b0, data: old_r};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fault_valid <= 1'b0;
            fault_code <= FLT_NONE;
        end
        else if (ce)
        begin
            fault_valid <= flt_any;
            if (acc_nat)
                fault_code <= FLT_NAT;
            else if (acc_unal)
                fault_code <= FLT_UNAL;
            else if (priv_bad)
                fault_code <= FLT_PRIV;
        end
    end

    // ***********************************************
    // registers
    // ***********************************************
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            en_r <= AFA_CTRL_RST[AFA_CTRL_EN_BIT];
            mask_r <= AFA_MASK_RST;
            count_r <= AFA_COUNT_RST;
            status_r <= '0;
            rdata_r <= 32'h0;
        end
        else if (ce)
        begin
            if (reg_wr && sel_ctrl)
                en_r <= reg_wdata[AFA_CTRL_EN_BIT];
            if (reg_wr && sel_mask)
                mask_r <= reg_wdata[AFA_ST_W-1:0];
            if (wr_done)
                count_r <= count_r + 32'h1;
            // a new event wins over a clear in the same cycle
            status_r <= (status_r & ~w1c) | ev_set;
            rdata_r <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // ***********************************************
    // assertions
    // ***********************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    size_match_a: assert property (
        $rose(mem_rd_req) |-> mem_size8 == op_r.wide && mem_paddr == paddr_r)
        else $error("operand width or address wrong at read");

    sum_value_a: assert property (
        (ce && rd_done) |=> mem_wr_req && mem_wr_data == afa_zext(op_r.wide,
            afa_zext(op_r.wide, $past(mem_rd_data)) + afa_inc_value(op_r.inc_code)))
        else $error("written sum does not match read value plus increment");

    result_a: assert property (
        (ce && wr_done) |=> wb_valid && !wb.nat && wb.data == old_r && wb.dst == op_r.dst)
        else $error("write-back value or token wrong");

    acq_hold_a: assert property (
        (mem_rd_req || mem_wr_req) && op_r.acq |-> ord_acq_hold)
        else $error("acquire hold missing during rmw");

    rel_wait_a: assert property (
        $rose(mem_rd_req) && !op_r.acq |-> $past(ord_prior_idle))
        else $error("release read issued before earlier accesses finished");

    lock_span_a: assert property (
        (ce && rd_done) |=> mem_lock [*1] ##0 mem_wr_req)
        else $error("lock dropped between read and write");

    align_fault_a: assert property (
        acc_unal |=> fault_valid && fault_code == FLT_UNAL && state_r == ST_IDLE)
        else $error("misaligned address not faulted");

    priv_check_a: assert property (
        (ce && priv_bad) |=> fault_valid && fault_code == FLT_PRIV && !mem_rd_req)
        else $error("missing privilege not faulted");

    skip_op_a: assert property (
        acc_skip |=> state_r == ST_IDLE && !wb_valid && !fault_valid && !mem_lock)
        else $error("false predicate caused activity");

    nat_fault_a: assert property (
        acc_nat |=> fault_valid && fault_code == FLT_NAT && !tr_req && !mem_lock)
        else $error("address token not faulted");

    full_op_c: cover property (acc_go ##[3:40] wb_valid);
    priv_fault_c: cover property (tr_req ##1 (fault_valid && fault_code == FLT_PRIV));
    rel_wait_c: cover property ((state_r == ST_ORDER) && !ord_prior_idle [*2] ##1 mem_rd_req);
    irq_c: cover property ($rose(irq));

endmodule

/* rtl/afa_pkg.sv */
// shared constants, types and helpers of the atomic fetch-add unit
package afa_pkg;

    // ***********************************************
    // register map (byte offsets, one word each)
    // ***********************************************
    localparam logic [7:0] AFA_OFS_CTRL = 8'h00;
    localparam logic [7:0] AFA_OFS_STATUS = 8'h04;
    localparam logic [7:0] AFA_OFS_MASK = 8'h08;
    localparam logic [7:0] AFA_OFS_RES_LO = 8'h0C;
    localparam logic [7:0] AFA_OFS_RES_HI = 8'h10;
    localparam logic [7:0] AFA_OFS_OPCOUNT = 8'h14;

    // ***********************************************
    // field positions and reset values
    // ***********************************************
    localparam int AFA_CTRL_EN_BIT = 0;
    localparam int AFA_ST_DONE_BIT = 0;
    localparam int AFA_ST_NAT_BIT = 1;
    localparam int AFA_ST_UNAL_BIT = 2;
    localparam int AFA_ST_PRIV_BIT = 3;
    localparam int AFA_ST_W = 4;
    localparam logic [31:0] AFA_CTRL_RST = 32'h0000_0001;
    localparam logic [AFA_ST_W-1:0] AFA_MASK_RST = 4'h0;
    localparam logic [31:0] AFA_COUNT_RST = 32'h0000_0000;

    // ***********************************************
    // types
    // ***********************************************
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_XLATE = 3'b001,
        ST_ORDER = 3'b011,
        ST_READ = 3'b010,
        ST_WRITE = 3'b110,
        ST_DONE = 3'b111
    } afa_state_e;

    typedef enum logic [1:0]
    {
        FLT_NONE = 2'h0,
        FLT_NAT = 2'h1,
        FLT_UNAL = 2'h2,
        FLT_PRIV = 2'h3
    } afa_fault_e;

    // one issued operation: wide=1 is atomic_add_word64, else atomic_add_word32
    typedef struct packed
    {
        logic qp;
        logic wide;
        logic acq;
        logic [1:0] ldhint;
        logic [2:0] inc_code;
        logic [6:0] dst;
        logic addr_nat;
        logic [63:0] addr;
    } afa_req_s;

    // write-back to the general_register file
    typedef struct packed
    {
        logic [6:0] dst;
        logic nat;
        logic [63:0] data;
    } afa_wb_s;

    // ***********************************************
    // helpers
    // ***********************************************
    // increment code 0..7 selects -16,-8,-4,-1,+1,+4,+8,+16
    function automatic logic [63:0] afa_inc_value(input logic [2:0] code);
        logic [63:0] v;
        v = 64'h0;
        unique case (code)
            3'h0: v = 64'hFFFF_FFFF_FFFF_FFF0;
            3'h1: v = 64'hFFFF_FFFF_FFFF_FFF8;
            3'h2: v = 64'hFFFF_FFFF_FFFF_FFFC;
            3'h3: v = 64'hFFFF_FFFF_FFFF_FFFF;
            3'h4: v = 64'h0000_0000_0000_0001;
            3'h5: v = 64'h0000_0000_0000_0004;
            3'h6: v = 64'h0000_0000_0000_0008;
            3'h7: v = 64'h0000_0000_0000_0010;
        endcase
        return v;
    endfunction

    function automatic logic [63:0] afa_zext(input logic wide, input logic [63:0] d);
        return wide ? d : {32'h0000_0000, d[31:0]};
    endfunction

    function automatic logic afa_misaligned(input logic wide, input logic [63:0] a);
        return wide ? (a[2:0] != 3'h0) : (a[1:0] != 2'h0);
    endfunction

endpackage

/* rtl/afa_sum.sv */
// adder of the fetch-add unit: zero-extended old value plus signed increment
`timescale 1ns/100ps
module afa_sum
    import afa_pkg::*;
(
    // operand
    input wire logic wide,
    input wire logic [2:0] inc_code,
    input wire logic [63:0] old_val,
    // result
    output logic [63:0] new_val
);

    logic [63:0] old_ext;
    logic [63:0] raw_sum;

    assign old_ext = afa_zext(wide, old_val);
    assign raw_sum = old_ext + afa_inc_value(inc_code);
    // narrow form keeps only the low four bytes of the sum
    assign new_val = afa_zext(wide, raw_sum);

endmodule

/* bench/afa_mem_model.sv */
// far-side model: page translation with privilege answers and a small data memory
`timescale 1ns/100ps
module afa_mem_model
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // scenario controls
    input wire logic [1:0] delay,
    input wire logic rd_ok,
    input wire logic wr_ok,
    // translation
    input wire logic tr_req,
    input wire logic [63:0] tr_vaddr,
    output logic tr_ack,
    output logic tr_rd_ok,
    output logic tr_wr_ok,
    output logic [63:0] tr_paddr,
    // memory
    input wire logic mem_lock,
    input wire logic mem_rd_req,
    input wire logic mem_wr_req,
    input wire logic mem_size8,
    input wire logic [63:0] mem_paddr,
    input wire logic [63:0] mem_wr_data,
    output logic mem_rd_ack,
    output logic [63:0] mem_rd_data,
    output logic mem_wr_ack
);
    logic [31:0] mem32 [0:31];
    logic [1:0] wait_r;
    logic in_rmw_r;
    logic [63:0] rmw_addr_r;
    int rd_count;
    int wr_count;
    logic lock_err;
    wire [4:0] idx = mem_paddr[6:2];
    wire go = (wait_r >= delay);

    // released lines toggle so a stale value is never mistaken for an answer
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tr_ack <= 1'b0;
            mem_rd_ack <= 1'b0;
            mem_wr_ack <= 1'b0;
            tr_rd_ok <= 1'b0;
            tr_wr_ok <= 1'b0;
            tr_paddr <= 64'h0;
            mem_rd_data <= 64'h0;
            wait_r <= 2'h0;
            in_rmw_r <= 1'b0;
            rmw_addr_r <= 64'h0;
            rd_count <= 0;
            wr_count <= 0;
            lock_err <= 1'b0;
        end
        else
        begin
            tr_ack <= 1'b0;
            mem_rd_ack <= 1'b0;
            mem_wr_ack <= 1'b0;
            tr_paddr <= ~tr_paddr;
            tr_rd_ok <= ~tr_rd_ok;
            tr_wr_ok <= ~tr_wr_ok;
            mem_rd_data <= ~mem_rd_data;
            wait_r <= wait_r + 2'h1;
            if (!(tr_req || mem_rd_req || mem_wr_req))
                wait_r <= 2'h0;
            if (tr_req && !tr_ack && go)
            begin
                tr_ack <= 1'b1;
                tr_paddr <= tr_vaddr;
                tr_rd_ok <= rd_ok;
                tr_wr_ok <= wr_ok;
                wait_r <= 2'h0;
            end
            // narrow reads carry junk above the word to expose missing zero-extension
            if (mem_rd_req && !mem_rd_ack && go)
            begin
                mem_rd_ack <= 1'b1;
                mem_rd_data <= {mem_size8 ? mem32[idx + 5'h1] : ~mem32[idx], mem32[idx]};
                rd_count <= rd_count + 1;
                in_rmw_r <= 1'b1;
                rmw_addr_r <= mem_paddr;
                wait_r <= 2'h0;
            end
            if (mem_wr_req && !mem_wr_ack && go)
            begin
                mem_wr_ack <= 1'b1;
                mem32[idx] <= mem_wr_data[31:0];
                if (mem_size8)
                    mem32[idx + 5'h1] <= mem_wr_data[63:32];
                wr_count <= wr_count + 1;
                in_rmw_r <= 1'b0;
                if (!in_rmw_r || mem_paddr != rmw_addr_r)
                    lock_err <= 1'b1;
                wait_r <= 2'h0;
            end
            if (in_rmw_r && !mem_lock)
                lock_err <= 1'b1;
        end
    end
endmodule

/* bench/testbench.sv */
// self-checking bench of the atomic fetch-add unit
`timescale 1ns/100ps
module testbench;
    import afa_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic issue_valid = 1'b0;
    afa_req_s issue_req = '0;
    logic ord_prior_idle = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] delay = 2'h0;
    logic rd_ok = 1'b1;
    logic wr_ok = 1'b1;
    logic issue_ready, wb_valid, fault_valid, tr_req, tr_ack, tr_rd_ok, tr_wr_ok, irq;
    logic ord_acq_hold, mem_lock, mem_rd_req, mem_wr_req, mem_size8, mem_rd_ack, mem_wr_ack;
    logic [1:0] mem_ldhint;
    logic [63:0] tr_vaddr, tr_paddr, mem_paddr, mem_wr_data, mem_rd_data;
    logic [31:0] reg_rdata;
    afa_wb_s wb;
    afa_fault_e fault_code;
    int errors = 0;
    int cmp_count = 0;
    int n_ok = 0;
    logic [63:0] last_old = 64'h0;
    int incs [8] = '{-16, -8, -4, -1, 1, 4, 8, 16};

    always #5 core_clk = ~core_clk;

    afa_unit dut (.core_clk(core_clk), .reset_n(reset_n), .ce(ce), .issue_valid(issue_valid),
        .issue_req(issue_req), .issue_ready(issue_ready), .wb_valid(wb_valid), .wb(wb),
        .fault_valid(fault_valid), .fault_code(fault_code), .tr_req(tr_req), .tr_vaddr(tr_vaddr),
        .tr_ack(tr_ack), .tr_rd_ok(tr_rd_ok), .tr_wr_ok(tr_wr_ok), .tr_paddr(tr_paddr),
        .ord_prior_idle(ord_prior_idle), .ord_acq_hold(ord_acq_hold), .mem_lock(mem_lock),
        .mem_rd_req(mem_rd_req), .mem_wr_req(mem_wr_req), .mem_size8(mem_size8),
        .mem_ldhint(mem_ldhint), .mem_paddr(mem_paddr), .mem_wr_data(mem_wr_data),
        .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data), .mem_wr_ack(mem_wr_ack),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));

    afa_mem_model mdl (.core_clk(core_clk), .reset_n(reset_n), .delay(delay), .rd_ok(rd_ok),
        .wr_ok(wr_ok), .tr_req(tr_req), .tr_vaddr(tr_vaddr), .tr_ack(tr_ack),
        .tr_rd_ok(tr_rd_ok), .tr_wr_ok(tr_wr_ok), .tr_paddr(tr_paddr), .mem_lock(mem_lock),
        .mem_rd_req(mem_rd_req), .mem_wr_req(mem_wr_req), .mem_size8(mem_size8),
        .mem_paddr(mem_paddr), .mem_wr_data(mem_wr_data), .mem_rd_ack(mem_rd_ack),
        .mem_rd_data(mem_rd_data), .mem_wr_ack(mem_wr_ack));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(n, 64'(reg_rdata), 64'(e));
    endtask

    function automatic afa_req_s mk(input logic qp, input logic wide, input logic acq,
        input logic [2:0] code, input logic [63:0] addr, input logic nat);
        afa_req_s r;
        r = '{qp: qp, wide: wide, acq: acq, ldhint: code[1:0], inc_code: code,
            dst: {3'h0, addr[6:3]} + 7'h1, addr_nat: nat, addr: addr};
        return r;
    endfunction

    // issue one operation and judge write-back, fault and memory effects
    task automatic do_op(input afa_req_s r, input afa_fault_e ef, input logic [1:0] dly,
        input logic rok, input logic wok);
        logic [4:0] ix;
        logic [31:0] hi;
        logic [63:0] old;
        logic [63:0] sum;
        afa_wb_s prev;
        int rc;
        int wc;
        int n;
        logic got_wb;
        logic got_flt;
        logic good;
        ix = r.addr[6:2];
        hi = mdl.mem32[ix + 5'h1];
        old = {r.wide ? hi : 32'h0000_0000, mdl.mem32[ix]};
        sum = old + 64'(incs[r.inc_code]);
        good = r.qp && (ef == FLT_NONE);
        prev = wb;
        rc = mdl.rd_count;
        wc = mdl.wr_count;
        got_wb = 1'b0;
        got_flt = 1'b0;
        n = 0;
        @(posedge core_clk);
        issue_valid <= 1'b1;
        issue_req <= r;
        delay <= dly;
        rd_ok <= rok;
        wr_ok <= wok;
        #1;
        while (!issue_ready && n < 50)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        @(posedge core_clk);
        issue_valid <= 1'b0;
        for (n = 0; n < 40 && !got_wb && !got_flt; n++)
        begin
            #1;
            got_wb = wb_valid;
            got_flt = fault_valid;
            if (r.acq && mem_rd_req)
                check("acq_hold", 64'(ord_acq_hold), 64'h1);
            if (mem_rd_req)
                check("ldhint", 64'(mem_ldhint), 64'(r.ldhint));
            if (mem_rd_req)
                check("size8", 64'(mem_size8), 64'(r.wide));
            if (!got_wb && !got_flt)
                @(posedge core_clk);
        end
        check("wb_valid", 64'(got_wb), 64'(good));
        check("fault_valid", 64'(got_flt), 64'(r.qp && ef != FLT_NONE));
        if (got_flt)
            check("fault_code", 64'(fault_code), 64'(ef));
        check("writes", 64'(mdl.wr_count - wc), 64'(good));
        check("reads", 64'(mdl.rd_count - rc), 64'(good));
        check("lock", 64'(mdl.lock_err), 64'h0);
        if (good)
        begin
            n_ok++;
            last_old = old;
            check("wb_data", wb.data, old);
            check("wb_dst_nat", 64'({wb.dst, wb.nat}), 64'({r.dst, 1'b0}));
            check("mem_lo", 64'(mdl.mem32[ix]), 64'(sum[31:0]));
            check("mem_hi", 64'(mdl.mem32[ix + 5'h1]), 64'(r.wide ? sum[63:32] : hi));
        end
        else
            check("wb_kept", wb.data, prev.data);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_regs();
        rchk("ctrl", AFA_OFS_CTRL, AFA_CTRL_RST);
        rchk("mask", AFA_OFS_MASK, 32'(AFA_MASK_RST));
        rchk("status", AFA_OFS_STATUS, 32'h0000_0000);
        rchk("count", AFA_OFS_OPCOUNT, AFA_COUNT_RST);
        reg_wr_t(AFA_OFS_RES_LO, 32'hFFFF_FFFF);
        rchk("res_ro", AFA_OFS_RES_LO, 32'h0000_0000);
        rchk("unmapped", 8'h3C, 32'h0000_0000);
        reg_wr_t(AFA_OFS_CTRL, 32'h0000_0000);
        #1;
        check("ready_off", 64'(issue_ready), 64'h0);
        reg_wr_t(AFA_OFS_CTRL, AFA_CTRL_RST);
        // clock enable low: a register write must be frozen out
        ce <= 1'b0;
        reg_wr_t(AFA_OFS_MASK, 32'h0000_000F);
        ce <= 1'b1;
        rchk("ce_freeze", AFA_OFS_MASK, 32'(AFA_MASK_RST));
    endtask

    // every increment code; narrow and wide alternate, both orderings, varied ack delay
    task automatic test_incs();
        for (int k = 0; k < 8; k++)
            do_op(mk(1'b1, k[0], k[1], 3'(k), 64'h1000 + 64'(8 * k), 1'b0), FLT_NONE,
                2'(k % 3), 1'b1, 1'b1);
    endtask

    task automatic test_release();
        int rc;
        rc = mdl.rd_count;
        @(posedge core_clk);
        ord_prior_idle <= 1'b0;
        fork
            do_op(mk(1'b1, 1'b1, 1'b0, 3'h5, 64'h1040, 1'b0), FLT_NONE, 2'h1, 1'b1, 1'b1);
            begin
                repeat (15) @(posedge core_clk);
                check("early_read", 64'(mdl.rd_count - rc), 64'h0);
                ord_prior_idle <= 1'b1;
            end
        join
    endtask

    task automatic test_faults();
        do_op(mk(1'b1, 1'b0, 1'b0, 3'h3, 64'h1002, 1'b0), FLT_UNAL, 2'h0, 1'b1, 1'b1);
        do_op(mk(1'b1, 1'b1, 1'b1, 3'h4, 64'h1004, 1'b0), FLT_UNAL, 2'h0, 1'b1, 1'b1);
        do_op(mk(1'b1, 1'b1, 1'b0, 3'h4, 64'h1004, 1'b1), FLT_NAT, 2'h0, 1'b1, 1'b1);
        do_op(mk(1'b1, 1'b0, 1'b1, 3'h7, 64'h1008, 1'b0), FLT_PRIV, 2'h2, 1'b1, 1'b0);
        do_op(mk(1'b1, 1'b1, 1'b0, 3'h0, 64'h1010, 1'b0), FLT_PRIV, 2'h0, 1'b0, 1'b1);
        do_op(mk(1'b0, 1'b1, 1'b0, 3'h6, 64'h1018, 1'b0), FLT_NONE, 2'h0, 1'b1, 1'b1);
    endtask

    task automatic test_irq();
        rchk("status", AFA_OFS_STATUS, 32'h0000_000F);
        rchk("count", AFA_OFS_OPCOUNT, 32'(n_ok));
        rchk("res_lo", AFA_OFS_RES_LO, last_old[31:0]);
        rchk("res_hi", AFA_OFS_RES_HI, last_old[63:32]);
        reg_wr_t(AFA_OFS_MASK, 32'h0000_0008);
        #1;
        check("irq_on", 64'(irq), 64'h1);
        reg_wr_t(AFA_OFS_STATUS, 32'h0000_0008);
        #1;
        check("irq_off", 64'(irq), 64'h0);
        rchk("status_w1c", AFA_OFS_STATUS, 32'h0000_0007);
    endtask

    initial
    begin
        for (int i = 0; i < 32; i++)
            mdl.mem32[i] = 32'hFFFF_FFF8 + 32'(i);
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        test_regs();
        test_incs();
        test_release();
        test_faults();
        test_irq();
        conclude();
    end

    // about 250 cycles are needed; forty times that means a hang
    initial
    begin
        #100000;
        errors++;
        conclude();
    end
endmodule
